/* rtl/pgop_decode.sv */
`timescale 1ns/1ps
// What this block does
// - Selector picks channel 0-11 or sensor 13-17.
// - Unsupported command on target sets comm fault.
// - Common commands behave alike on every target.
// - Channel n maps to sense, enable, DAC line.
// - Selector 13 internal, 14-17 external sensors.
// - Values 12, 18-254 reserved; 255 means all.
// - Everything reachable through one bus address.
// - Byte 00h turns supply off immediately.
// - Byte 40h turns supply off with delay.
// - 80h on; 94h/98h low; A4h/A8h high margin.
// - 94h/A4h suppress faults; 98h/A8h act normally.
// - Invalid byte sets fault and asserts alert.
// - Command disabled keeps on/off, applies margin.
// - Supply holds mode until new command or pin.
// - On/off combines command and control pin.
// - Margining starts only after power good or pg_force_i.
// - Act only on enabled channels.
// - Individually selected channel is not sequenced.
// - Config bit 3 enables on/off command part.
// - Reading power command returns standard bytes only.
module pgop_decode
    import pgop_pkg::*;
#(
    parameter logic [6:0] BUS_ADDR = 7'h40,
    parameter int CH = 12
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic [4:0] on_off_cfg_i,
    input wire logic control_pin_i,
    input wire logic [CH-1:0] chan_enable_i,
    input wire logic pg_all_i,
    input wire logic pg_force_i,
    input wire logic fault_clear_i,
    output logic [CH-1:0] supply_enable_n_o,
    output logic [CH-1:0] off_now_o,
    output logic [CH-1:0] sequenced_o,
    output logic [CH-1:0] margin_low_o,
    output logic [CH-1:0] margin_high_o,
    output logic [CH-1:0] margin_active_o,
    output logic [CH-1:0] fault_ignore_o,
    output logic [7:0] target_selector_o,
    output logic [7:0] sel_dac_addr_o,
    output logic [1:0] sel_dac_current_line_o,
    output logic [7:0] sel_sensor_addr_o,
    output logic sel_internal_temp_o,
    output logic comm_logic_fault_bit_o,
    output logic alert_n_o
);
    // Elaboration check: the selector decode serves exactly NUM_CH channels.
    if (CH != NUM_CH) begin : g_bad_ch
        $error("pgop_decode: channel count must equal NUM_CH.");
    end

    // Power command byte is one of the listed standard values.
    function automatic logic op_valid(input logic [7:0] b);
        op_valid = (b == OP_OFF_NOW) || (b == OP_OFF_SOFT) || (b == OP_ON)
            || (b == OP_LOW_IGN) || (b == OP_LOW_ACT)
            || (b == OP_HIGH_IGN) || (b == OP_HIGH_ACT);
    endfunction : op_valid

    // Selector value names one voltage channel.
    function automatic logic is_chan(input logic [7:0] s);
        is_chan = (s <= SEL_LAST_CH);
    endfunction : is_chan

    // Selector value is accepted (channel, sensor or all).
    function automatic logic sel_ok(input logic [7:0] s);
        sel_ok = is_chan(s) || ((s >= SEL_TEMP_INT) && (s <= SEL_TEMP_LAST))
            || (s == SEL_ALL);
    endfunction : sel_ok

    // Synchroniser stages; stage one feeds only stage two.
    logic scl_s1, scl_s2, scl_d;
    logic sda_s1, sda_s2, sda_d;
    logic ctl_s1, ctl_s2;
    // Serial engine state.
    pgop_state_t state;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] cmd;
    logic byte_idx;
    logic rd;
    logic [7:0] tx_byte;
    // Stored registers.
    logic [7:0] target_sel;
    logic [7:0] op_reg [CH];
    logic [7:0] op_all;
    logic [CH-1:0] cmd_on;
    logic fault;
    // Event strobes from the serial engine.
    logic data_done;
    logic cmd_bad;
    logic op_bad;

    // Edge and condition detection on the synchronised bus lines.
    wire scl_rise = scl_s2 & ~scl_d;
    wire scl_fall = ~scl_s2 & scl_d;
    wire start_c = scl_s2 & scl_d & sda_d & ~sda_s2;
    wire stop_c = scl_s2 & scl_d & ~sda_d & sda_s2;
    wire byte_end = scl_rise && (bit_cnt == 3'd7);
    wire [7:0] rx_byte = {shreg[6:0], sda_s2};

    // Two flip-flops on the control pin and three on each bus line (two to synchronise, one for edges), all from outside the clock.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {scl_s1, scl_s2, scl_d} <= 3'b111;
            {sda_s1, sda_s2, sda_d} <= 3'b111;
            {ctl_s1, ctl_s2} <= 2'b00;
        end else if (clk_en_i) begin
            {scl_s1, scl_s2, scl_d} <= {scl_i, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_d} <= {sda_i, sda_s1, sda_s2};
            {ctl_s1, ctl_s2} <= {control_pin_i, ctl_s1};
        end
    end

    // Read data for the command in hand; mirrors are standard bytes only.
    always_comb begin
        tx_byte = 8'h00;
        if (cmd == CMD_TARGET_SELECTOR) begin
            tx_byte = target_sel;
        end else if (is_chan(target_sel)) begin
            tx_byte = op_reg[target_sel[3:0]];
        end else if (target_sel == SEL_ALL) begin
            tx_byte = op_all;
        end
    end

    // Byte strobes: data byte done, unsupported or wrong-target command bytes, invalid power bytes.
    always_comb begin
        data_done = (state == PGOP_RX) && byte_end && byte_idx;
        cmd_bad = (state == PGOP_RX) && byte_end && !byte_idx
            && !((rx_byte == CMD_TARGET_SELECTOR)
            || ((rx_byte == CMD_POWER_COMMAND)
            && (is_chan(target_sel) || (target_sel == SEL_ALL))));
        op_bad = data_done && (cmd == CMD_POWER_COMMAND) && !op_valid(rx_byte);
    end

    // Serial slave engine: one bus address serves every target.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= PGOP_IDLE;
            bit_cnt <= 3'd0;
            shreg <= 8'h00;
            cmd <= 8'h00;
            byte_idx <= 1'b0;
            rd <= 1'b0;
            sda_o <= 1'b1;
            sda_oe_n_o <= 1'b1;
        end else if (clk_en_i) begin
            if (start_c) begin
                // Start or repeated start begins an address byte.
                state <= PGOP_ADDR;
                bit_cnt <= 3'd0;
                byte_idx <= 1'b0;
                sda_oe_n_o <= 1'b1;
            end else if (stop_c) begin
                state <= PGOP_IDLE;
                sda_oe_n_o <= 1'b1;
            end else begin
                unique case (state)
                    PGOP_IDLE, PGOP_SKIP: begin
                        sda_oe_n_o <= 1'b1;
                    end
                    PGOP_ADDR, PGOP_RX: begin
                        if (scl_rise) begin
                            shreg <= rx_byte;
                            bit_cnt <= bit_cnt + 3'd1;
                        end
                        if (byte_end && (state == PGOP_ADDR)) begin
                            if (rx_byte[7:1] == BUS_ADDR) begin
                                rd <= rx_byte[0];
                                state <= PGOP_ACK;
                            end else begin
                                state <= PGOP_SKIP;
                            end
                        end else if (byte_end) begin
                            if (!byte_idx) begin
                                cmd <= rx_byte;
                            end
                            byte_idx <= 1'b1;
                            state <= PGOP_ACK;
                        end else if (scl_fall && (bit_cnt == 3'd0)) begin
                            sda_oe_n_o <= 1'b1;
                        end
                    end
                    PGOP_ACK: begin
                        // Drive the acknowledge low for one bit time.
                        if (scl_fall && sda_oe_n_o) begin
                            sda_o <= 1'b0;
                            sda_oe_n_o <= 1'b0;
                            bit_cnt <= 3'd0;
                            shreg <= tx_byte;
                        end else if (scl_fall) begin
                            if (rd) begin
                                state <= PGOP_TX;
                                sda_o <= shreg[7];
                                sda_oe_n_o <= shreg[7];
                            end else begin
                                state <= PGOP_RX;
                                sda_oe_n_o <= 1'b1;
                            end
                        end
                    end
                    PGOP_TX: begin
                        // Shift read data out; a one is left to the pull-up.
                        if (scl_fall) begin
                            if (bit_cnt == 3'd7) begin
                                state <= PGOP_RACK;
                                sda_oe_n_o <= 1'b1;
                                bit_cnt <= 3'd0;
                            end else begin
                                sda_o <= shreg[6];
                                sda_oe_n_o <= shreg[6];
                                shreg <= {shreg[6:0], 1'b0};
                                bit_cnt <= bit_cnt + 3'd1;
                            end
                        end
                    end
                    PGOP_RACK: begin
                        // Host acknowledge keeps reading; a not-ack ends it.
                        // On a not-ack the line stays released, so no false start.
                        if (scl_rise) begin
                            shreg <= tx_byte;
                            state <= sda_s2 ? PGOP_SKIP : PGOP_ACK;
                            sda_oe_n_o <= sda_s2;
                        end
                    end
                    default: state <= PGOP_IDLE;
                endcase
            end
        end
    end

    // Target selector held until a new accepted value is written.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            target_sel <= RST_TARGET;
        end else if (clk_en_i && data_done && (cmd == CMD_TARGET_SELECTOR)) begin
            if (sel_ok(rx_byte)) begin
                target_sel <= rx_byte;
            end
        end
    end

    // Communication fault flag; a new event wins over the clear.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fault <= 1'b0;
        end else if (clk_en_i) begin
            if (cmd_bad || op_bad || (data_done && (cmd == CMD_TARGET_SELECTOR)
                && !sel_ok(rx_byte))) begin
                fault <= 1'b1;
            end else if (fault_clear_i) begin
                fault <= 1'b0;
            end
        end
    end

    // Per-channel power command state; each channel is reached by its own selector value or by the all-targets value.
    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_ch
            wire hit = (target_sel == SEL_ALL) || (target_sel == 8'(g));
            wire take = clk_en_i && data_done && (cmd == CMD_POWER_COMMAND)
                && op_valid(rx_byte) && hit && chan_enable_i[g];
            // Stored command byte and derived margin state.
            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    op_reg[g] <= RST_POWER;
                    margin_low_o[g] <= 1'b0;
                    margin_high_o[g] <= 1'b0;
                    fault_ignore_o[g] <= 1'b0;
                end else if (take) begin
                    op_reg[g] <= rx_byte;
                    margin_low_o[g] <= (rx_byte == OP_LOW_IGN) || (rx_byte == OP_LOW_ACT);
                    margin_high_o[g] <= (rx_byte == OP_HIGH_IGN) || (rx_byte == OP_HIGH_ACT);
                    fault_ignore_o[g] <= (rx_byte == OP_LOW_IGN) || (rx_byte == OP_HIGH_IGN);
                end
            end
            // On/off part, applied only when the config enables it.
            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    cmd_on[g] <= 1'b0;
                    off_now_o[g] <= 1'b0;
                    sequenced_o[g] <= 1'b0;
                end else if (take && on_off_cfg_i[CFG_CMD_EN]) begin
                    cmd_on[g] <= rx_byte[7];
                    off_now_o[g] <= (rx_byte == OP_OFF_NOW);
                    sequenced_o[g] <= (target_sel == SEL_ALL);
                end
            end
            wire pin_on = (ctl_s2 == on_off_cfg_i[CFG_PIN_POL]);
            wire run = (!on_off_cfg_i[CFG_CMD_EN] || cmd_on[g])
                && (!on_off_cfg_i[CFG_PIN_EN] || pin_on);
            // Enable output registered, active low like a supply-enable pin.
            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    supply_enable_n_o[g] <= 1'b1;
                    margin_active_o[g] <= 1'b0;
                end else if (clk_en_i) begin
                    supply_enable_n_o[g] <= ~(run && chan_enable_i[g]);
                    margin_active_o[g] <= (margin_low_o[g] | margin_high_o[g]) && run
                        && (pg_all_i || pg_force_i);
                end
            end
        end
    endgenerate

    // Copy of the last byte written with the all-targets selector.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            op_all <= RST_POWER;
        end else if (clk_en_i && data_done && (cmd == CMD_POWER_COMMAND)
            && op_valid(rx_byte) && (target_sel == SEL_ALL)) begin
            op_all <= rx_byte;
        end
    end

    // Resources of the selected target, registered.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sel_dac_addr_o <= 8'h00;
            sel_dac_current_line_o <= 2'd0;
            sel_sensor_addr_o <= 8'h00;
            sel_internal_temp_o <= 1'b0;
        end else if (clk_en_i) begin
            sel_dac_addr_o <= !is_chan(target_sel) ? 8'h00 :
                (target_sel[3:2] == 2'd0) ? DAC_ADDR_G0 :
                (target_sel[3:2] == 2'd1) ? DAC_ADDR_G1 : DAC_ADDR_G2;
            sel_dac_current_line_o <= target_sel[1:0];
            sel_internal_temp_o <= (target_sel == SEL_TEMP_INT);
            sel_sensor_addr_o <= ((target_sel > SEL_TEMP_INT) && (target_sel <= SEL_TEMP_LAST))
                ? 8'(SENSOR_BASE + 8'({target_sel - SEL_TEMP_INT - 8'd1, 1'b0})) : 8'h00;
        end
    end

    assign target_selector_o = target_sel;
    assign comm_logic_fault_bit_o = fault;
    assign alert_n_o = ~fault;
endmodule : pgop_decode

/* rtl/pgop_pkg.sv */
package pgop_pkg;
    // Number of voltage channels and the all-targets selector value.
    localparam int NUM_CH = 12;
    localparam logic [7:0] SEL_LAST_CH = 8'h0B;
    localparam logic [7:0] SEL_RSVD = 8'h0C;
    localparam logic [7:0] SEL_TEMP_INT = 8'h0D;
    localparam logic [7:0] SEL_TEMP_LAST = 8'h11;
    localparam logic [7:0] SEL_ALL = 8'hFF;
    // Command codes reached over the serial bus.
    localparam logic [7:0] CMD_TARGET_SELECTOR = 8'h00;
    localparam logic [7:0] CMD_POWER_COMMAND = 8'h01;
    // Power command data bytes.
    localparam logic [7:0] OP_OFF_NOW = 8'h00;
    localparam logic [7:0] OP_OFF_SOFT = 8'h40;
    localparam logic [7:0] OP_ON = 8'h80;
    localparam logic [7:0] OP_LOW_IGN = 8'h94;
    localparam logic [7:0] OP_LOW_ACT = 8'h98;
    localparam logic [7:0] OP_HIGH_IGN = 8'hA4;
    localparam logic [7:0] OP_HIGH_ACT = 8'hA8;
    // Reset values of the two registers.
    localparam logic [7:0] RST_TARGET = 8'h00;
    localparam logic [7:0] RST_POWER = 8'h00;
    // External DAC addresses per group of four channels.
    localparam logic [7:0] DAC_ADDR_G0 = 8'h20;
    localparam logic [7:0] DAC_ADDR_G1 = 8'h60;
    localparam logic [7:0] DAC_ADDR_G2 = 8'hA0;
    // External sensor base address, step of two per sensor.
    localparam logic [7:0] SENSOR_BASE = 8'h90;
    // Field positions in the on/off configuration input.
    localparam int CFG_CMD_EN = 3;
    localparam int CFG_PIN_EN = 2;
    localparam int CFG_PIN_POL = 1;
    localparam int CFG_PIN_NOW = 0;
    // Serial engine states.
    typedef enum logic [2:0] {
        PGOP_IDLE = 3'b000,
        PGOP_ADDR = 3'b001,
        PGOP_ACK = 3'b010,
        PGOP_RX = 3'b011,
        PGOP_TX = 3'b100,
        PGOP_RACK = 3'b101,
        PGOP_SKIP = 3'b110
    } pgop_state_t;
endpackage : pgop_pkg

/* verification/pgop_decode_props.sv */
`timescale 1ns/1ps
// Watches selector decode, fault flag and margin gating at the ports.
module pgop_decode_props
    import pgop_pkg::*;
#(
    parameter int CH = 12
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic pg_all_i,
    input wire logic pg_force_i,
    input wire logic fault_clear_i,
    input wire logic [CH-1:0] margin_active_o,
    input wire logic [7:0] target_selector_o,
    input wire logic [7:0] sel_dac_addr_o,
    input wire logic [1:0] sel_dac_current_line_o,
    input wire logic [7:0] sel_sensor_addr_o,
    input wire logic sel_internal_temp_o,
    input wire logic comm_logic_fault_bit_o,
    input wire logic alert_n_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    AST_SEL_LEGAL: assert property (
        target_selector_o <= SEL_LAST_CH || target_selector_o == SEL_ALL ||
        (target_selector_o >= SEL_TEMP_INT && target_selector_o <= SEL_TEMP_LAST))
        else $error("selector holds a reserved value");
    AST_DAC_MAP: assert property (rstn_i && target_selector_o <= SEL_LAST_CH |=>
        sel_dac_addr_o == ($past(target_selector_o) < 8'h04 ? DAC_ADDR_G0 :
        $past(target_selector_o) < 8'h08 ? DAC_ADDR_G1 : DAC_ADDR_G2))
        else $error("converter address wrong for channel");
    AST_DAC_LINE: assert property (target_selector_o <= SEL_LAST_CH |=>
        sel_dac_current_line_o == $past(target_selector_o[1:0]))
        else $error("converter line wrong for channel");
    AST_SENSOR: assert property (
        target_selector_o > SEL_TEMP_INT && target_selector_o <= SEL_TEMP_LAST |=>
        sel_sensor_addr_o == SENSOR_BASE + 8'h02 * ($past(target_selector_o) - 8'h0E))
        else $error("sensor address wrong");
    AST_INT_TEMP: assert property (1'b1 |=>
        sel_internal_temp_o == ($past(target_selector_o) == SEL_TEMP_INT))
        else $error("internal sensor select wrong");
    AST_ALERT: assert property (comm_logic_fault_bit_o |-> ##[0:1] !alert_n_o)
        else $error("alert not raised with fault");
    AST_FAULT_STICKY: assert property (
        comm_logic_fault_bit_o && !fault_clear_i |=> comm_logic_fault_bit_o)
        else $error("fault dropped without clear");
    AST_MARGIN_PG: assert property ((!pg_all_i && !pg_force_i) [*2] |->
        margin_active_o == '0)
        else $error("margining active without power good");
endmodule : pgop_decode_props
bind pgop_decode pgop_decode_props #(.CH(CH)) pgop_decode_props_inst (.*);

/* verification/pgop_decode_tb_top.sv */
`timescale 1ns/1ps
// Drives the decoder over its serial port and judges its outputs.
module pgop_decode_tb_top
    import pgop_pkg::*;
;
    localparam logic [6:0] ADDR = 7'h40;
    logic sys_clk_i, rstn_i, clk_en_i, scl_i, sda_i, control_pin_i, hsda, ok;
    logic pg_all_i, pg_force_i, fault_clear_i, sda_o, sda_oe_n_o;
    logic sel_internal_temp_o, comm_logic_fault_bit_o, alert_n_o;
    logic [4:0] on_off_cfg_i;
    logic [11:0] chan_enable_i, supply_enable_n_o, off_now_o, sequenced_o;
    logic [11:0] margin_low_o, margin_high_o, margin_active_o, fault_ignore_o;
    logic [7:0] target_selector_o, sel_dac_addr_o, sel_sensor_addr_o, rb;
    logic [1:0] sel_dac_current_line_o;
    int n_errors = 0;
    int num_checks = 0;
    // Pulled-up data line, low when either party pulls it.
    assign sda_i = hsda & (sda_oe_n_o | sda_o);
    pgop_decode pgop_decode_inst (.*);
    pgop_host_model pgop_host_model_inst (
        .sys_clk_i(sys_clk_i),
        .sda_w_i(sda_i),
        .scl_o(scl_i),
        .sda_o(hsda)
    );
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    task automatic chk_b(input logic [7:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t byte %h expected %h", $time, got, exp);
        end
    endtask : chk_b
    task automatic chk_v(input logic [11:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t vector %h expected %h", $time, got, exp);
        end
    endtask : chk_v
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : idle
    task automatic w(input logic [7:0] c, d);
        pgop_host_model_inst.wr(ADDR, c, d, ok);
        chk_v({11'h000, ok}, 12'h001);
    endtask : w
    task automatic r(input logic [7:0] c);
        pgop_host_model_inst.rd(ADDR, c, rb);
    endtask : r
    task automatic clr();
        fault_clear_i <= 1'b1;
        idle(2);
        fault_clear_i <= 1'b0;
        idle(2);
    endtask : clr
    task automatic t_select();
        logic [7:0] s, e;
        for (int i = 0; i < 18; i++) begin
            s = 8'(i);
            e = s < 8'h04 ? DAC_ADDR_G0 : s < 8'h08 ? DAC_ADDR_G1 : DAC_ADDR_G2;
            if (s != SEL_RSVD) begin
                w(CMD_TARGET_SELECTOR, s);
                r(CMD_TARGET_SELECTOR);
                chk_b(rb, s);
                chk_b(target_selector_o, s);
                if (s <= SEL_LAST_CH) begin
                    chk_b(sel_dac_addr_o, e);
                    chk_v({10'h000, sel_dac_current_line_o}, 12'(i % 4));
                end else begin
                    chk_v({11'h000, sel_internal_temp_o}, {11'h000, i == 13});
                    e = i == 13 ? 8'h00 : SENSOR_BASE + 8'(2 * (i - 14));
                    chk_b(sel_sensor_addr_o, e);
                end
            end
        end
    endtask : t_select
    task automatic t_refuse();
        logic [7:0] bad [3] = '{SEL_RSVD, 8'h12, 8'hFE};
        w(CMD_TARGET_SELECTOR, 8'h05);
        foreach (bad[k]) begin
            clr();
            w(CMD_TARGET_SELECTOR, bad[k]);
            chk_v({11'h000, comm_logic_fault_bit_o}, 12'h001);
            chk_b(target_selector_o, 8'h05);
        end
        clr();
        chk_v({11'h000, comm_logic_fault_bit_o}, 12'h000);
        w(8'h05, 8'h00);
        chk_v({11'h000, comm_logic_fault_bit_o}, 12'h001);
        clr();
        w(CMD_TARGET_SELECTOR, SEL_TEMP_INT);
        w(CMD_POWER_COMMAND, OP_ON);
        chk_v({11'h000, comm_logic_fault_bit_o}, 12'h001);
        clr();
        pgop_host_model_inst.wr(7'h41, CMD_TARGET_SELECTOR, 8'h05, ok);
        chk_v({11'h000, ok}, 12'h000);
        chk_b(target_selector_o, SEL_TEMP_INT);
    endtask : t_refuse
    task automatic t_power();
        logic [7:0] ops [7] = '{OP_ON, OP_LOW_IGN, OP_LOW_ACT, OP_HIGH_IGN,
            OP_HIGH_ACT, OP_OFF_SOFT, OP_OFF_NOW};
        w(CMD_TARGET_SELECTOR, 8'h03);
        foreach (ops[k]) begin
            w(CMD_POWER_COMMAND, ops[k]);
            r(CMD_POWER_COMMAND);
            chk_b(rb, ops[k]);
            chk_v(supply_enable_n_o, {8'hFF, !ops[k][7], 3'h7});
            if (!ops[k][7]) begin
                chk_v({11'h000, off_now_o[3]}, {11'h000, k == 6});
            end else begin
                chk_v({10'h000, margin_low_o[3], margin_high_o[3]},
                    {10'h000, ops[k][5:4] == 2'b01, ops[k][5:4] == 2'b10});
                chk_v({11'h000, fault_ignore_o[3]}, {11'h000, ops[k][3:2] == 2'b01});
                chk_v({11'h000, margin_active_o[3]}, 12'h000);
            end
        end
        w(CMD_POWER_COMMAND, OP_HIGH_ACT);
        pg_force_i <= 1'b1;
        idle(4);
        chk_v({11'h000, margin_active_o[3]}, 12'h001);
        w(CMD_POWER_COMMAND, 8'h55);
        chk_v({8'h00, alert_n_o, comm_logic_fault_bit_o, margin_high_o[3],
            supply_enable_n_o[3]}, 12'h006);
        pg_force_i <= 1'b0;
        pg_all_i <= 1'b1;
        idle(4);
        chk_v({11'h000, margin_active_o[3]}, 12'h001);
        pg_all_i <= 1'b0;
        idle(4);
        chk_v({11'h000, margin_active_o[3]}, 12'h000);
        clr();
        on_off_cfg_i <= 5'h00;
        w(CMD_POWER_COMMAND, OP_OFF_NOW);
        chk_v({10'h000, supply_enable_n_o[3], margin_high_o[3]}, 12'h000);
        w(CMD_POWER_COMMAND, OP_HIGH_IGN);
        chk_v({10'h000, supply_enable_n_o[3], margin_high_o[3]}, 12'h001);
        on_off_cfg_i <= 5'h08;
        chan_enable_i <= 12'hFF7;
        w(CMD_POWER_COMMAND, OP_OFF_NOW);
        chk_v({10'h000, supply_enable_n_o[3], off_now_o[3]}, 12'h002);
        chan_enable_i <= 12'hFFF;
        idle(4);
        chk_v({11'h000, supply_enable_n_o[3]}, 12'h000);
    endtask : t_power
    task automatic t_all();
        w(CMD_TARGET_SELECTOR, SEL_ALL);
        w(CMD_POWER_COMMAND, OP_ON);
        chk_v(supply_enable_n_o | ~sequenced_o, 12'h000);
        w(CMD_TARGET_SELECTOR, 8'h05);
        w(CMD_POWER_COMMAND, OP_OFF_SOFT);
        chk_v(supply_enable_n_o, 12'h020);
        chk_v({10'h000, off_now_o[5], sequenced_o[5]}, 12'h000);
        on_off_cfg_i <= 5'h0E;
        idle(12);
        chk_v(supply_enable_n_o, 12'hFFF);
        control_pin_i <= 1'b1;
        idle(12);
        chk_v(supply_enable_n_o, 12'h020);
    endtask : t_all
    task automatic conclude();
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    initial begin
        rstn_i = 1'b0;
        clk_en_i = 1'b1;
        control_pin_i = 1'b0;
        pg_all_i = 1'b0;
        pg_force_i = 1'b0;
        fault_clear_i = 1'b0;
        on_off_cfg_i = 5'h08;
        chan_enable_i = 12'hFFF;
        idle(2);
        rstn_i <= 1'b1;
        idle(4);
        chk_b(target_selector_o, RST_TARGET);
        chk_v({alert_n_o, supply_enable_n_o[10:0]}, 12'hFFF);
        t_select();
        t_refuse();
        t_power();
        t_all();
        conclude();
    end
    initial begin
        #2_000_000;
        n_errors++;
        conclude();
    end
endmodule : pgop_decode_tb_top

/* verification/pgop_host_model.sv */
`timescale 1ns/1ps
// Bus host: clock line idles high, data is open drain, 8 cycles a bit.
module pgop_host_model (
    input wire logic sys_clk_i,
    input wire logic sda_w_i,
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : hold
    // Start or repeated start: data falls while the clock is high.
    task automatic start();
        sda_o <= 1'b1;
        hold(2);
        scl_o <= 1'b1;
        hold(2);
        sda_o <= 1'b0;
        hold(2);
        scl_o <= 1'b0;
        hold(2);
    endtask : start
    task automatic stop();
        sda_o <= 1'b0;
        hold(2);
        scl_o <= 1'b1;
        hold(2);
        sda_o <= 1'b1;
        hold(4);
    endtask : stop
    // Data set while the clock is low, line sampled at the end of high.
    task automatic xbit(input logic b, output logic q);
        sda_o <= b;
        hold(2);
        scl_o <= 1'b1;
        hold(4);
        q = sda_w_i;
        scl_o <= 1'b0;
        hold(2);
    endtask : xbit
    // Eight bits MSB first, then a released acknowledge slot.
    task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], b);
            q[i] = b;
        end
        xbit(1'b1, b);
        ack = !b;
    endtask : xbyte
    task automatic wr(input logic [6:0] a, input logic [7:0] c, d, output logic ok);
        logic [7:0] q;
        logic k0, k1, k2;
        start();
        xbyte({a, 1'b0}, q, k0);
        xbyte(c, q, k1);
        xbyte(d, q, k2);
        stop();
        ok = k0 & k1 & k2;
    endtask : wr
    // Read ends with a not-acknowledge from the host.
    task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d);
        logic [7:0] q;
        logic k;
        start();
        xbyte({a, 1'b0}, q, k);
        xbyte(c, q, k);
        start();
        xbyte({a, 1'b1}, q, k);
        xbyte(8'hFF, d, k);
        stop();
    endtask : rd
endmodule : pgop_host_model
